/* dv/compact_timer_assertions.sv */
`timescale 1ns/1ns
module compact_timer_assertions #(
  parameter int CNT_WIDTH = 10,
  parameter int COARSE_WIDTH = 3
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic INTERNAL_HIGH_CLOCK_TICK,
  input wire logic TIMEBASE_CLOCK_TICK,
  input wire logic EXTERNAL_COUNT_INPUT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_OUTPUT_PIN,
  input wire logic TIMER_OUTPUT_PIN_OE,
  input wire logic COMPARE_A_FLAG,
  input wire logic COMPARE_P_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_setup;
    PSEL && !PENABLE && CE;
  endsequence
  sequence s_read_high;
    s_setup ##0 (!PWRITE && (PADDR == 8'h0C || PADDR == 8'h14));
  endsequence
  a_zero_wait: assert property (s_setup |=> PREADY)
    else $error("no answer in the access cycle");
  a_ready_pulse: assert property (PREADY && CE |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_bad_addr: assert property (s_setup ##0 PADDR > 8'h18 |=>
    PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
  a_good_addr: assert property (s_setup ##0 (PADDR <= 8'h18 &&
    PADDR[1:0] == 2'h0) |=> !PSLVERR) else $error("mapped access refused");
  a_byte_width: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data above the byte");
  a_high_unused: assert property (s_read_high |=>
    PRDATA[7:2] == 6'h0) else $error("unused high bits not zero");
  a_flag_a_hold: assert property ($fell(COMPARE_A_FLAG) |->
    $past(PSEL && PENABLE && PWRITE && PADDR == 8'h18 && PWDATA[0]))
    else $error("flag a dropped without clear");
  a_flag_p_hold: assert property ($fell(COMPARE_P_FLAG) |->
    $past(PSEL && PENABLE && PWRITE && PADDR == 8'h18 && PWDATA[1]))
    else $error("flag p dropped without clear");
  a_frozen_out: assert property (!CE |=> $stable({TIMER_OUTPUT_PIN,
    COMPARE_A_FLAG, COMPARE_P_FLAG})) else $error("moved while disabled");
endmodule // compact_timer_assertions
bind compact_timer compact_timer_assertions #(.CNT_WIDTH(CNT_WIDTH),
  .COARSE_WIDTH(COARSE_WIDTH)) chk (.CLK(CLK), .RESETN(RESETN), .CE(CE),
  .INTERNAL_HIGH_CLOCK_TICK(INTERNAL_HIGH_CLOCK_TICK),
  .TIMEBASE_CLOCK_TICK(TIMEBASE_CLOCK_TICK),
  .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
  .TIMER_OUTPUT_PIN_OE(TIMER_OUTPUT_PIN_OE),
  .COMPARE_A_FLAG(COMPARE_A_FLAG), .COMPARE_P_FLAG(COMPARE_P_FLAG));

/* dv/compact_timer_test.sv */
`timescale 1ns/1ns
module compact_timer_test;
  logic clk, rstn, ce, tick, psel, pen, pwr, e;
  logic [7:0] paddr, lo, hi, c1;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pin, oe, fa, fp;
  logic [32:0] exp_q[$];
  int n_fail, check_count, seed, k;
  compact_timer dut (.CLK(clk), .RESETN(rstn), .CE(ce),
    .INTERNAL_HIGH_CLOCK_TICK(tick), .TIMEBASE_CLOCK_TICK(1'h0),
    .EXTERNAL_COUNT_INPUT(1'h0), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TIMER_OUTPUT_PIN(pin), .TIMER_OUTPUT_PIN_OE(oe),
    .COMPARE_A_FLAG(fa), .COMPARE_P_FLAG(fp));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task check(string name, logic [32:0] seen, logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(logic w, logic [7:0] a, logic [7:0] d, logic [32:0] x);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back(x);
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task rd(logic [7:0] a, logic [7:0] v);
    apb(1'h0, a, 8'h00, {25'h0, v});
  endtask
  task wr(logic [7:0] a, logic [7:0] v);
    apb(1'h1, a, v, 33'h0);
  endtask
  task rd_cnt(logic [9:0] c);
    rd(ctimer_pkg::OFS_COUNTER_HIGH, {6'h00, c[9:8]});
    rd(ctimer_pkg::OFS_COUNTER_LOW, c[7:0]);
  endtask
  task ticks(int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'h1;
      @(posedge clk);
      tick <= 1'h0;
    end
  endtask
  task pin_is(string name, logic v);
    repeat (3) @(posedge clk);
    check(name, {32'h0, pin}, {32'h0, v});
  endtask
  // reads are compared as the answer lands, in request order
  always @(posedge clk) begin
    if (psel && pen && pready === 1'h1 && !pwr)
      check("read", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    seed = 95;
    {rstn, ce, tick, psel, pen, pwr, paddr, pwdata} = 46'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    ce <= 1'h1;
    for (k = 0; k < 6; k++) rd(8'(k * 4), 8'h00);
    lo = 8'($random(seed)) & 8'hF7;
    c1 = 8'($random(seed)) & 8'h3F;
    wr(ctimer_pkg::OFS_CONTROL_FIRST, lo);
    wr(ctimer_pkg::OFS_CONTROL_SECOND, c1);
    rd(ctimer_pkg::OFS_CONTROL_FIRST, lo);
    rd(ctimer_pkg::OFS_CONTROL_SECOND, c1);
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    wr(ctimer_pkg::OFS_COMPARE_A_LOW, lo);
    wr(ctimer_pkg::OFS_COMPARE_A_HIGH, hi);
    rd(ctimer_pkg::OFS_COMPARE_A_HIGH, {6'h00, hi[1:0]});
    rd(ctimer_pkg::OFS_COMPARE_A_LOW, lo);
    // a low write without its high write must not reach compare A
    wr(ctimer_pkg::OFS_COMPARE_A_LOW, ~lo);
    rd(ctimer_pkg::OFS_COMPARE_A_HIGH, {6'h00, hi[1:0]});
    rd(ctimer_pkg::OFS_COMPARE_A_LOW, lo);
    apb(1'h0, 8'h40, 8'h00, {1'h1, 32'h0});
    wr(ctimer_pkg::OFS_CONTROL_SECOND, 8'h00);
    wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h18);
    k = ($random(seed) & 31) + 1;
    ticks(k);
    rd_cnt(10'(k));
    wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h98);
    ticks(5);
    ce <= 1'h0;
    ticks(3);
    ce <= 1'h1;
    wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h18);
    ticks(2);
    rd_cnt(10'(k + 2));
    wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h10);
    wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h18);
    rd_cnt(10'h000);
    for (k = 0; k < 8; k++) begin
      c1 = {2'h0, k[1:0], k[2], 1'($random(seed)), 2'h1};
      e = (k[1:0] == 2'h0) ? k[2] : (k[1:0] == 2'h3) ? !k[2] : k[1];
      wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h10);
      wr(ctimer_pkg::OFS_CONTROL_SECOND, c1);
      wr(ctimer_pkg::OFS_COMPARE_A_LOW, 8'h03);
      wr(ctimer_pkg::OFS_COMPARE_A_HIGH, 8'h00);
      wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h18);
      pin_is("start", c1[3] ^ c1[2]);
      ticks(3);
      pin_is("match", e ^ c1[2]);
      check("flags", {31'h0, fp, fa}, 33'h1);
      rd_cnt(10'h000);
      wr(ctimer_pkg::OFS_FLAGS, 8'h03);
    end
    // duty 200 above a 128 period: the running waveform stays active
    for (k = 0; k < 3; k++) begin
      wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h10);
      wr(ctimer_pkg::OFS_CONTROL_SECOND, {2'h2, k[1:0], 4'h8});
      wr(ctimer_pkg::OFS_COMPARE_A_LOW, 8'hC8);
      wr(ctimer_pkg::OFS_COMPARE_A_HIGH, 8'h00);
      wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h19);
      ticks(5);
      pin_is("pwm", k != 0);
    end
    wr(ctimer_pkg::OFS_CONTROL_FIRST, 8'h10);
    wr(ctimer_pkg::OFS_CONTROL_SECOND, 8'hC0);
    repeat (3) @(posedge clk);
    check("oe", {32'h0, oe}, 33'h0);
    complete_run;
  end
endmodule // compact_timer_test

/* logic/compact_timer.sv */
// Overview of operation
// - ten-bit up-counter steps once per selected timer clock edge when on, unpaused
// - comparator P checks 3-bit value against top three counter bits; A all ten
// - software cannot load the counter; it clears it only with an on-bit rising edge
// - counter self-clears on overflow or selected compare match, raising flags except on overflow in pwm mode
// - pause bit holds the counter value; clearing it resumes from there
// - clock select picks sys/4, high, high/16, high/64, timebase, pin edges
// - on-bit low stops and keeps count; rising edge zeroes and starts it
// - on-bit rising edge restores output initial level in compare mode
// - P period is coarse value times 128 clocks; zero means 1024
// - mode field selects compare, undefined, pwm, timer/counter
// - compare mode A match does nothing, drives low, high, or toggles
// - pwm function field forces inactive, forces active, or runs waveform
// - a match requesting the current initial level shows no pin change
// - initial-level bit is start level in compare, active level in pwm
// - polarity bit inverts the output pin except in timer/counter mode
// - swap bit 0 makes P the period, A the duty; 1 swaps them
// - clear-select 1 clears on A match, 0 on P match or overflow; ignored in pwm mode
// - live counter readable as low byte plus two-bit high byte
// - compare A value held in read/write low and high byte pair
// - low bytes pass a holding buffer moved on high-byte access
// - with clear-on-A in compare mode the P flag is never set
// - pwm duty equal to or above period gives full duty
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
module compact_timer #(
  parameter int CNT_WIDTH = 10,
  parameter int COARSE_WIDTH = 3
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic INTERNAL_HIGH_CLOCK_TICK,
  input wire logic TIMEBASE_CLOCK_TICK,
  input wire logic EXTERNAL_COUNT_INPUT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic TIMER_OUTPUT_PIN,
  output logic TIMER_OUTPUT_PIN_OE,
  output logic COMPARE_A_FLAG,
  output logic COMPARE_P_FLAG
);
  initial begin
    if (CNT_WIDTH != 10 || COARSE_WIDTH != 3)
      $error("compact_timer supports only a 10-bit counter, 3-bit coarse");
  end

  ctimer_pkg::control_first_t ctl0;
  ctimer_pkg::control_second_t ctl1;
  logic [CNT_WIDTH-1:0] count;
  logic [CNT_WIDTH-1:0] compare_a;
  logic [7:0] hold_buf;
  logic on_prev;
  logic pin_prev;
  logic out_level;
  logic [5:0] pre_sys;
  logic [5:0] pre_high;
  logic flag_a;
  logic flag_p;

  // apb decode: zero-wait slave, answers in the access cycle
  wire access = PSEL & PENABLE;
  wire wr = access & PWRITE;
  wire rd = access & ~PWRITE;
  wire hit_c0 = PADDR == ctimer_pkg::OFS_CONTROL_FIRST;
  wire hit_c1 = PADDR == ctimer_pkg::OFS_CONTROL_SECOND;
  wire hit_dl = PADDR == ctimer_pkg::OFS_COUNTER_LOW;
  wire hit_dh = PADDR == ctimer_pkg::OFS_COUNTER_HIGH;
  wire hit_al = PADDR == ctimer_pkg::OFS_COMPARE_A_LOW;
  wire hit_ah = PADDR == ctimer_pkg::OFS_COMPARE_A_HIGH;
  wire hit_fl = PADDR == ctimer_pkg::OFS_FLAGS;
  wire mapped = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al | hit_ah | hit_fl;
  wire [7:0] wbyte = PWDATA[7:0];

  // clock sources as one-cycle enables
  wire sys_tick = pre_sys[1:0] == 2'h3;
  wire high_div16_tick = INTERNAL_HIGH_CLOCK_TICK & (pre_high[3:0] == 4'hF);
  wire high_div64_tick = INTERNAL_HIGH_CLOCK_TICK & (pre_high == 6'h3F);
  wire pin_rise = EXTERNAL_COUNT_INPUT & ~pin_prev;
  wire pin_fall = ~EXTERNAL_COUNT_INPUT & pin_prev;
  logic tick;
  always_comb begin
    unique case (ctimer_pkg::clock_source_t'(ctl0.clock_select))
      ctimer_pkg::CLK_SYS_DIV4: tick = sys_tick;
      ctimer_pkg::CLK_HIGH: tick = INTERNAL_HIGH_CLOCK_TICK;
      ctimer_pkg::CLK_HIGH_DIV16: tick = high_div16_tick;
      ctimer_pkg::CLK_HIGH_DIV64: tick = high_div64_tick;
      ctimer_pkg::CLK_TIMEBASE_A: tick = TIMEBASE_CLOCK_TICK;
      ctimer_pkg::CLK_TIMEBASE_B: tick = TIMEBASE_CLOCK_TICK;
      ctimer_pkg::CLK_PIN_RISE: tick = pin_rise;
      ctimer_pkg::CLK_PIN_FALL: tick = pin_fall;
    endcase
  end

  wire is_pwm = ctl1.operating_mode_select == ctimer_pkg::MODE_PWM;
  wire is_cmp = ctl1.operating_mode_select == ctimer_pkg::MODE_COMPARE;
  wire is_tmr = ctl1.operating_mode_select == ctimer_pkg::MODE_TIMER;
  wire step = tick & ctl0.counter_on & ~ctl0.counter_pause;
  wire on_rise = ctl0.counter_on & ~on_prev;

  // matches are taken on the value the next step would reach
  wire [CNT_WIDTH-1:0] count_inc = count + 10'h001;
  wire wrap = &count;
  wire coarse_zero = ctl0.coarse_period_value == 3'h0;
  wire match_p = step & ~coarse_zero &
    (count_inc[9:7] == ctl0.coarse_period_value) &
    (count_inc[6:0] == 7'h00);
  wire match_a = step & (count_inc == compare_a) & (compare_a != 10'h000);
  // zero coarse value lets the counter run to overflow: 1024 clocks
  wire event_p = match_p | (step & wrap & coarse_zero);
  wire event_a = match_a | (step & wrap & (compare_a == 10'h000));

  // period and duty selection for pwm, in timer clocks
  wire [10:0] coarse_len = coarse_zero ? 11'h400 :
    {1'b0, ctl0.coarse_period_value, 7'h00};
  wire [10:0] fine_len = {1'b0, compare_a};
  wire [10:0] period_len = ctl1.period_duty_swap ? fine_len : coarse_len;
  wire [10:0] duty_len = ctl1.period_duty_swap ? coarse_len : fine_len;
  wire pwm_period_end = ctl1.period_duty_swap ? event_a : event_p;
  wire pwm_active = ({1'b0, count} < duty_len) |
    (duty_len >= period_len);

  wire clear_on_a = ctl1.counter_clear_select & ~is_pwm;
  wire count_clear = is_pwm ? pwm_period_end :
    (clear_on_a ? event_a : event_p);
  wire [CNT_WIDTH-1:0] next_count = on_rise ? 10'h000 :
    (step ? (count_clear ? 10'h000 : count_inc) : count);

  wire set_a = is_pwm ? match_a : (clear_on_a ? event_a : match_a);
  wire set_p = is_pwm ? match_p : (~clear_on_a & event_p);

  // compare mode: act on A matches only
  logic next_out;
  always_comb begin
    next_out = out_level;
    if (on_rise)
      next_out = ctl1.output_initial_level;
    else if (is_cmp && match_a) begin
      unique case (ctl1.output_function_select)
        2'h0: next_out = out_level;
        2'h1: next_out = 1'b0;
        2'h2: next_out = 1'b1;
        2'h3: next_out = ~out_level;
      endcase
    end
  end

  logic pwm_level;
  always_comb begin
    unique case (ctl1.output_function_select)
      2'h0: pwm_level = ~ctl1.output_initial_level;
      2'h1: pwm_level = ctl1.output_initial_level;
      2'h2: pwm_level = ctl1.output_initial_level ~^ pwm_active;
      2'h3: pwm_level = ~ctl1.output_initial_level;
    endcase
  end
  // timer/counter mode leaves the pin at its last driven level
  wire pin_raw = is_pwm ? pwm_level : out_level;
  wire next_pin = is_tmr ? TIMER_OUTPUT_PIN :
    pin_raw ^ ctl1.output_polarity_invert;

  // read mux; high-byte reads snapshot the low byte into the buffer
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit_c0) rbyte = ctl0;
    if (hit_c1) rbyte = ctl1;
    if (hit_dl || hit_al) rbyte = hold_buf;
    if (hit_dh) rbyte = {6'h00, count[9:8]};
    if (hit_ah) rbyte = {6'h00, compare_a[9:8]};
    if (hit_fl) rbyte = {6'h00, flag_p, flag_a};
  end

  wire [7:0] next_buf = (wr && hit_al) ? wbyte :
    (rd && hit_dh) ? count[7:0] :
    (rd && hit_ah) ? compare_a[7:0] : hold_buf;
  wire [9:0] next_compare_a = (wr && hit_ah) ?
    {wbyte[1:0], hold_buf} : compare_a;
  // hardware set wins over a software write-one-to-clear in the same cycle
  wire next_flag_a = set_a | (flag_a & ~(wr & hit_fl & wbyte[0]));
  wire next_flag_p = set_p | (flag_p & ~(wr & hit_fl & wbyte[1]));

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl0 <= ctimer_pkg::RST_CONTROL_FIRST;
      ctl1 <= ctimer_pkg::RST_CONTROL_SECOND;
      compare_a <= ctimer_pkg::RST_COMPARE_A;
      hold_buf <= 8'h00;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (wr && hit_c0) ctl0 <= wbyte;
      if (wr && hit_c1) ctl1 <= wbyte;
      compare_a <= next_compare_a;
      hold_buf <= next_buf;
      PRDATA <= {24'h000000, rbyte};
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      count <= 10'h000;
      on_prev <= 1'b0;
      pin_prev <= 1'b0;
      out_level <= 1'b0;
      pre_sys <= 6'h00;
      pre_high <= 6'h00;
      flag_a <= 1'b0;
      flag_p <= 1'b0;
      TIMER_OUTPUT_PIN <= 1'b0;
      TIMER_OUTPUT_PIN_OE <= 1'b0;
      COMPARE_A_FLAG <= 1'b0;
      COMPARE_P_FLAG <= 1'b0;
    end else if (CE) begin
      count <= next_count;
      on_prev <= ctl0.counter_on;
      pin_prev <= EXTERNAL_COUNT_INPUT;
      out_level <= next_out;
      pre_sys <= pre_sys + 6'h01;
      if (INTERNAL_HIGH_CLOCK_TICK) pre_high <= pre_high + 6'h01;
      flag_a <= next_flag_a;
      flag_p <= next_flag_p;
      TIMER_OUTPUT_PIN <= next_pin;
      TIMER_OUTPUT_PIN_OE <= ~is_tmr;
      COMPARE_A_FLAG <= next_flag_a;
      COMPARE_P_FLAG <= next_flag_p;
    end
  end
endmodule // compact_timer

/* logic/ctimer_pkg.sv */
package ctimer_pkg;
  // register word offsets (byte addresses on apb)
  localparam logic [7:0] OFS_CONTROL_FIRST = 8'h00;
  localparam logic [7:0] OFS_CONTROL_SECOND = 8'h04;
  localparam logic [7:0] OFS_COUNTER_LOW = 8'h08;
  localparam logic [7:0] OFS_COUNTER_HIGH = 8'h0C;
  localparam logic [7:0] OFS_COMPARE_A_LOW = 8'h10;
  localparam logic [7:0] OFS_COMPARE_A_HIGH = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  // reset values
  localparam logic [7:0] RST_CONTROL_FIRST = 8'h00;
  localparam logic [7:0] RST_CONTROL_SECOND = 8'h00;
  localparam logic [9:0] RST_COMPARE_A = 10'h000;
  // prescaler ratios
  localparam int DIV_SYSTEM = 4;
  localparam int DIV_HIGH_MID = 16;
  localparam int DIV_HIGH_SLOW = 64;
  // field layout of the first control register
  typedef struct packed {
    logic counter_pause;
    logic [2:0] clock_select;
    logic counter_on;
    logic [2:0] coarse_period_value;
  } control_first_t;
  // field layout of the second control register
  typedef struct packed {
    logic [1:0] operating_mode_select;
    logic [1:0] output_function_select;
    logic output_initial_level;
    logic output_polarity_invert;
    logic period_duty_swap;
    logic counter_clear_select;
  } control_second_t;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } mode_t;
  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'h0,
    CLK_HIGH = 3'h1,
    CLK_HIGH_DIV16 = 3'h2,
    CLK_HIGH_DIV64 = 3'h3,
    CLK_TIMEBASE_A = 3'h4,
    CLK_TIMEBASE_B = 3'h5,
    CLK_PIN_RISE = 3'h6,
    CLK_PIN_FALL = 3'h7
  } clock_source_t;
endpackage
